// *** logic/tcp_timer.sv ***
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Two 8-bit capture registers latch the counter on a chosen pin edge.
// - Capture registers are read-only; writes leave them unchanged.
// - Each channel has an edge select bit picking rising or falling.
// - Captured values resolve to one counter increment.
// - Control two holds a two-bit clock select for the counter rate.
// - One enable bit in control one lets both channels interrupt.
// - A capture sets the channel flag and loads the counter value.
// - Interrupt only when enabled and CPU mask clear; otherwise it pends.
// - Flag clears by status read while set, then capture register access.
// - Capture register holds the newest capture; each overwrites the last.
// - Both channels work at once and independently.
// - In PWM or single-shot mode only channel two captures.
// - Capture pins feed the timer directly whatever their port use.
// - PWM period from compare two, pulse length from compare one.
// - PWM takes over compare one and compare two; no compare events.
// - In PWM, compare writes apply only at the period end.
// - PWM and single-shot both set means PWM only.
// - PWM counter reset sets flag one, interrupting if enabled.
// - Halt freezes the counter; interrupt wake resumes, reset restarts.
// - Edge in halt arms capture; wake-up sets flag and captures.
// - All timer events share one interrupt, all gated by the one enable bit.
module tcp_timer
	import tcp_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              sys_rst_in,
	input  wire logic [TCP_AW-1:0] addr_in,
	input  wire logic [TCP_DW-1:0] wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output var  logic [TCP_DW-1:0] rdata_out,
	input  wire logic              capture_pin_one_in,
	input  wire logic              capture_pin_two_in,
	input  wire logic              cpu_irq_mask_in,
	input  wire logic              halt_in,
	output var  logic              irq_out,
	output var  logic              waveform_output_pin_out
);
	logic [7:0]        timer_control_one_r;
	logic [7:0]        timer_control_two_r;
	logic [7:0]        compare_value_one_r;
	logic [7:0]        compare_value_two_r;
	logic [7:0]        cmp1_act_r;
	logic [7:0]        cmp2_act_r;
	logic [7:0]        cnt_r;
	logic [7:0]        cap_r [2];
	logic [1:0]        flag_r;
	logic [1:0]        clr_arm_r;
	logic [1:0]        pin_vec;
	logic [1:0]        edge_sel;
	logic [1:0]        chan_evt;
	logic [1:0]        cap_evt;
	logic [1:0]        cap_acc;
	logic [1:0]        flag_set;
	logic              tick;
	logic              pwm_on;
	logic              shot_on;
	logic              period_end;
	logic              stat_rd;
	tcp_pwm_state_type pwm_st_r;

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	// PWM wins over single-shot when both are set
	assign pwm_on  = timer_control_two_r[TCP_B_PWM];
	assign shot_on = timer_control_two_r[TCP_B_SHOT] & ~pwm_on;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pwm_st_r <= TCP_PWM_IDLE;
		end else begin
			case (pwm_st_r)
				TCP_PWM_IDLE: begin
					if (pwm_on) begin
						pwm_st_r <= TCP_PWM_RUN;
					end
				end
				TCP_PWM_RUN: begin
					if (!pwm_on) begin
						pwm_st_r <= TCP_PWM_IDLE;
					end
				end
				default: pwm_st_r <= TCP_PWM_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Counter and prescaler
	// ------------------------------------------------------------
	tcp_tick_gen u_tick (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.sel_in     (timer_control_two_r[TCP_B_CLK +: 2]),
		.halt_in    (halt_in),
		.tick_out   (tick)
	);

	assign period_end = tick && (pwm_st_r == TCP_PWM_RUN) && (cnt_r == cmp2_act_r);

	// Halt suppresses ticks, so the count freezes and resumes in place
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cnt_r <= TCP_RST_CNT;
		end else if (period_end) begin
			cnt_r <= TCP_RST_CNT;
		end else if (tick) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// Capture channels
	// ------------------------------------------------------------
	assign pin_vec  = {capture_pin_two_in, capture_pin_one_in};
	assign edge_sel = {timer_control_two_r[TCP_B_EDGE], timer_control_one_r[TCP_B_EDGE]};
	assign stat_rd  = rd_in && (addr_in == TCP_A_STAT);

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_chan
			tcp_capture_chan u_chan (
				.clk_in     (clk_in),
				.sys_rst_in (sys_rst_in),
				.pin_in     (pin_vec[gi]),
				.rising_in  (edge_sel[gi]),
				.halt_in    (halt_in),
				.event_out  (chan_evt[gi])
			);

			// Channel one is lost to the waveform logic in PWM and single-shot
			if (gi == 0) begin : g_one
				assign cap_evt[gi] = chan_evt[gi] & ~pwm_on & ~shot_on;
			end else begin : g_two
				assign cap_evt[gi] = chan_evt[gi];
			end

			assign cap_acc[gi] = (rd_in | wr_in) && (addr_in == (gi == 0 ? TCP_A_CAP1 : TCP_A_CAP2));
			assign flag_set[gi] = cap_evt[gi] | ((gi == 0) & period_end);

			// Newest capture overwrites; bus writes never reach it
			always_ff @(posedge clk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					cap_r[gi] <= TCP_RST_REG;
				end else if (cap_evt[gi]) begin
					cap_r[gi] <= cnt_r;
				end
			end

			// First step of the clear: status seen while flag set
			always_ff @(posedge clk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					clr_arm_r[gi] <= 1'b0;
				end else if (stat_rd && flag_r[gi]) begin
					clr_arm_r[gi] <= 1'b1;
				end else if (cap_acc[gi] || !flag_r[gi]) begin
					clr_arm_r[gi] <= 1'b0;
				end
			end

			// Set wins over a clear landing in the same cycle
			always_ff @(posedge clk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					flag_r[gi] <= 1'b0;
				end else if (flag_set[gi]) begin
					flag_r[gi] <= 1'b1;
				end else if (clr_arm_r[gi] && cap_acc[gi]) begin
					flag_r[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Interrupt request
	// ------------------------------------------------------------
	// Flags stay set while masked, so the request simply pends
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= timer_control_one_r[TCP_B_IRQEN] & (|flag_r) & ~cpu_irq_mask_in;
		end
	end

	// ------------------------------------------------------------
	// Control and compare registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			timer_control_one_r <= TCP_RST_REG;
			timer_control_two_r <= TCP_RST_REG;
			compare_value_one_r <= TCP_RST_CMP;
			compare_value_two_r <= TCP_RST_CMP;
		end else if (wr_in) begin
			case (addr_in)
				TCP_A_CTRL1: timer_control_one_r <= wdata_in;
				TCP_A_CTRL2: timer_control_two_r <= wdata_in;
				TCP_A_CMP1:  compare_value_one_r <= wdata_in;
				TCP_A_CMP2:  compare_value_two_r <= wdata_in;
				default:     ;
			endcase
		end
	end

	// Working copies only move at the period end while running
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cmp1_act_r <= TCP_RST_CMP;
			cmp2_act_r <= TCP_RST_CMP;
		end else if (pwm_st_r != TCP_PWM_RUN || period_end) begin
			cmp1_act_r <= compare_value_one_r;
			cmp2_act_r <= compare_value_two_r;
		end
	end

	// ------------------------------------------------------------
	// Waveform output
	// ------------------------------------------------------------
	// High from counter reset until compare one; low outside PWM
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			waveform_output_pin_out <= 1'b0;
		end else if (pwm_st_r != TCP_PWM_RUN) begin
			waveform_output_pin_out <= 1'b0;
		end else if (period_end) begin
			waveform_output_pin_out <= 1'b1;
		end else if (tick && cnt_r == cmp1_act_r) begin
			waveform_output_pin_out <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	// Data appear one cycle after the strobe; idle cycles read zero
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rdata_out <= '0;
		end else if (rd_in) begin
			case (addr_in)
				TCP_A_CTRL1: rdata_out <= timer_control_one_r;
				TCP_A_CTRL2: rdata_out <= timer_control_two_r;
				TCP_A_STAT:  rdata_out <= {flag_r[0], flag_r[1], 6'h00};
				TCP_A_CAP1:  rdata_out <= cap_r[0];
				TCP_A_CAP2:  rdata_out <= cap_r[1];
				TCP_A_CMP1:  rdata_out <= compare_value_one_r;
				TCP_A_CMP2:  rdata_out <= compare_value_two_r;
				default:     rdata_out <= cnt_r;
			endcase
		end else begin
			rdata_out <= '0;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_cap_load;
		@(posedge clk_in) disable iff (sys_rst_in)
		cap_evt[1] |=> cap_r[1] == $past(cnt_r);
	endproperty
	a_cap_load: assert property (p_cap_load) else $error("capture value wrong");

	property p_cap_ro;
		@(posedge clk_in) disable iff (sys_rst_in)
		wr_in && addr_in == TCP_A_CAP1 && !cap_evt[0] |=> $stable(cap_r[0]);
	endproperty
	a_cap_ro: assert property (p_cap_ro) else $error("capture register written");

	property p_flag_set;
		@(posedge clk_in) disable iff (sys_rst_in)
		cap_evt[0] |=> flag_r[0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set");

	property p_flag_keep;
		@(posedge clk_in) disable iff (sys_rst_in)
		flag_r[1] && !(clr_arm_r[1] && cap_acc[1]) |=> flag_r[1];
	endproperty
	a_flag_keep: assert property (p_flag_keep) else $error("flag cleared early");

	property p_irq;
		@(posedge clk_in) disable iff (sys_rst_in)
		##1 irq_out == $past(timer_control_one_r[TCP_B_IRQEN] && |flag_r && !cpu_irq_mask_in);
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");

	property p_ch1_off;
		@(posedge clk_in) disable iff (sys_rst_in)
		(pwm_on || timer_control_two_r[TCP_B_SHOT]) |=> $stable(cap_r[0]);
	endproperty
	a_ch1_off: assert property (p_ch1_off) else $error("channel one captured");

	property p_pwm_idle_low;
		@(posedge clk_in) disable iff (sys_rst_in)
		!pwm_on ##1 !pwm_on |=> !waveform_output_pin_out;
	endproperty
	a_pwm_idle_low: assert property (p_pwm_idle_low) else $error("pin active outside pwm");

	property p_period_flag;
		@(posedge clk_in) disable iff (sys_rst_in)
		period_end |=> flag_r[0] && cnt_r == TCP_RST_CNT && waveform_output_pin_out;
	endproperty
	a_period_flag: assert property (p_period_flag) else $error("period end wrong");

	property p_dbl_buf;
		@(posedge clk_in) disable iff (sys_rst_in)
		pwm_st_r == TCP_PWM_RUN && !period_end |=> $stable(cmp1_act_r) && $stable(cmp2_act_r);
	endproperty
	a_dbl_buf: assert property (p_dbl_buf) else $error("compare changed mid period");

	property p_wrap;
		@(posedge clk_in) disable iff (sys_rst_in)
		tick && !period_end && cnt_r == 8'hff |=> cnt_r == TCP_RST_CNT;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter wrap wrong");

	property p_halt_freeze;
		@(posedge clk_in) disable iff (sys_rst_in)
		halt_in && $past(halt_in) |=> $stable(cnt_r);
	endproperty
	a_halt_freeze: assert property (p_halt_freeze) else $error("counter ran in halt");

	c_cap_two: cover property (@(posedge clk_in) disable iff (sys_rst_in) cap_evt[1]);
	c_period:  cover property (@(posedge clk_in) disable iff (sys_rst_in) period_end);
	c_clear:   cover property (@(posedge clk_in) disable iff (sys_rst_in) $fell(flag_r[0]));
	c_irq:     cover property (@(posedge clk_in) disable iff (sys_rst_in) $rose(irq_out));
endmodule : tcp_timer
`default_nettype wire

// *** logic/tcp_pkg.sv ***
`default_nettype none
package tcp_pkg;
	// ------------------------------------------------------------
	// Register map and widths
	// ------------------------------------------------------------
	localparam int unsigned TCP_DW      = 8;
	localparam int unsigned TCP_AW      = 3;
	localparam logic [2:0]  TCP_A_CTRL1 = 3'h0;
	localparam logic [2:0]  TCP_A_CTRL2 = 3'h1;
	localparam logic [2:0]  TCP_A_STAT  = 3'h2;
	localparam logic [2:0]  TCP_A_CAP1  = 3'h3;
	localparam logic [2:0]  TCP_A_CAP2  = 3'h4;
	localparam logic [2:0]  TCP_A_CMP1  = 3'h5;
	localparam logic [2:0]  TCP_A_CMP2  = 3'h6;
	localparam logic [2:0]  TCP_A_CNT   = 3'h7;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned TCP_B_IRQEN = 7;
	localparam int unsigned TCP_B_EDGE  = 1;
	localparam int unsigned TCP_B_PWM   = 7;
	localparam int unsigned TCP_B_SHOT  = 6;
	localparam int unsigned TCP_B_CLK   = 2;
	localparam int unsigned TCP_B_FLAG1 = 7;
	localparam int unsigned TCP_B_FLAG2 = 6;
	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [7:0]  TCP_RST_REG = 8'h00;
	localparam logic [7:0]  TCP_RST_CNT = 8'h00;
	localparam logic [7:0]  TCP_RST_CMP = 8'hff;
	localparam int unsigned TCP_PRE_W   = 7;
	localparam logic [6:0]  TCP_DIV_M0  = 7'h01;
	localparam logic [6:0]  TCP_DIV_M1  = 7'h07;
	localparam logic [6:0]  TCP_DIV_M2  = 7'h1f;
	localparam logic [6:0]  TCP_DIV_M3  = 7'h7f;
	typedef enum logic [1:0] {
		TCP_PWM_IDLE = 2'b01,
		TCP_PWM_RUN  = 2'b10
	} tcp_pwm_state_type;
endpackage : tcp_pkg
`default_nettype wire

// *** logic/tcp_tick_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcp_tick_gen
	import tcp_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       sys_rst_in,
	input  wire logic [1:0] sel_in,
	input  wire logic       halt_in,
	output var  logic       tick_out
);
	logic [TCP_PRE_W-1:0] div_r;
	logic [TCP_PRE_W-1:0] mask;

	// ------------------------------------------------------------
	// Divider: ticks at 1/2, 1/8, 1/32 or 1/128 of clk_in
	// ------------------------------------------------------------
	always_comb begin
		case (sel_in)
			2'h0:    mask = TCP_DIV_M0;
			2'h1:    mask = TCP_DIV_M1;
			2'h2:    mask = TCP_DIV_M2;
			default: mask = TCP_DIV_M3;
		endcase
	end

	// Halt stops the prescaler too, so the count resumes in phase
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			div_r    <= '0;
			tick_out <= 1'b0;
		end else if (halt_in) begin
			tick_out <= 1'b0;
		end else begin
			div_r    <= div_r + 1'b1;
			tick_out <= ((div_r & mask) == mask);
		end
	end
endmodule : tcp_tick_gen
`default_nettype wire

// *** logic/tcp_capture_chan.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcp_capture_chan
	import tcp_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic sys_rst_in,
	input  wire logic pin_in,
	input  wire logic rising_in,
	input  wire logic halt_in,
	output var  logic event_out
);
	logic sync1_r;
	logic sync2_r;
	logic last_r;
	logic armed_r;
	logic edge_hit;

	// ------------------------------------------------------------
	// Pin synchroniser and edge detect
	// ------------------------------------------------------------
	// The pin feeds the timer whatever the port does with it
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			last_r  <= 1'b0;
		end else begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
			last_r  <= sync2_r;
		end
	end

	assign edge_hit = rising_in ? (sync2_r & ~last_r) : (~sync2_r & last_r);

	// Edge during halt is held and fires on wake-up
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			armed_r   <= 1'b0;
			event_out <= 1'b0;
		end else if (halt_in) begin
			event_out <= 1'b0;
			if (edge_hit) begin
				armed_r <= 1'b1;
			end
		end else begin
			armed_r   <= 1'b0;
			event_out <= edge_hit | armed_r;
		end
	end

	property p_halt_silent;
		@(posedge clk_in) disable iff (sys_rst_in)
		halt_in |=> !event_out;
	endproperty
	a_halt_silent: assert property (p_halt_silent) else $error("capture fired in halt");
endmodule : tcp_capture_chan
`default_nettype wire

// *** tb/tcp_ext_src.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Capture pin sources and waveform load
// ------------------------------------------------------------
module tcp_ext_src (
	input  wire logic        clk_in,
	input  wire logic        wave_in,
	output var  logic        pin_one_out,
	output var  logic        pin_two_out,
	output var  logic [15:0] period_out,
	output var  logic [15:0] high_out
);
	logic [15:0] run_r;
	logic        wave_r;

	// Pins always sit at a driven level, as a floating input fed by a source
	initial begin
		pin_one_out = 1'b0;
		pin_two_out = 1'b0;
		run_r       = 16'h0000;
		wave_r      = 1'b0;
		period_out  = 16'h0000;
		high_out    = 16'h0000;
	end

	// Level held four cycles so the synchroniser cannot miss it
	task automatic set_pin(input int which, input logic lvl);
		@(posedge clk_in);
		if (which == 1) begin
			pin_one_out <= lvl;
		end else begin
			pin_two_out <= lvl;
		end
		repeat (3) @(posedge clk_in);
	endtask : set_pin

	// Load side: cycles between rises and the high time of each pulse
	always @(posedge clk_in) begin
		wave_r <= wave_in;
		run_r  <= (wave_in && !wave_r) ? 16'h0001 : run_r + 16'h0001;
		if (wave_in && !wave_r) begin
			period_out <= run_r;
		end
		if (!wave_in && wave_r) begin
			high_out <= run_r;
		end
	end
endmodule : tcp_ext_src
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import tcp_pkg::*;
;
	logic              clk_in;
	logic              sys_rst_in;
	logic [TCP_AW-1:0] addr_in;
	logic [TCP_DW-1:0] wdata_in;
	logic              wr_in;
	logic              rd_in;
	logic [TCP_DW-1:0] rdata_out;
	logic              pin_one;
	logic              pin_two;
	logic              mask_in;
	logic              halt_in;
	logic              irq_out;
	logic              wave;
	logic [15:0]       period_len;
	logic [15:0]       high_len;
	logic [7:0]        rv;
	logic [7:0]        c0;
	logic [7:0]        c1;
	logic [7:0]        h0;
	int                error_cnt;
	int                cmp_count;

	// ------------------------------------------------------------
	// Design, pin sources and load
	// ------------------------------------------------------------
	tcp_timer dut_u (
		.clk_in                  (clk_in),
		.sys_rst_in              (sys_rst_in),
		.addr_in                 (addr_in),
		.wdata_in                (wdata_in),
		.wr_in                   (wr_in),
		.rd_in                   (rd_in),
		.rdata_out               (rdata_out),
		.capture_pin_one_in      (pin_one),
		.capture_pin_two_in      (pin_two),
		.cpu_irq_mask_in         (mask_in),
		.halt_in                 (halt_in),
		.irq_out                 (irq_out),
		.waveform_output_pin_out (wave)
	);
	tcp_ext_src src_u (
		.clk_in      (clk_in),
		.wave_in     (wave),
		.pin_one_out (pin_one),
		.pin_two_out (pin_two),
		.period_out  (period_len),
		.high_out    (high_len)
	);

	always #20 clk_in = ~clk_in;

	// ------------------------------------------------------------
	// Bus tasks and checks
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("Compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : reg_wr

	// Data is taken in the single cycle it stands
	task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask : reg_rd

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
		reg_rd(a, rv);
		check(rv, e);
	endtask : rd_chk

	// Bounded wait for a waveform level, then one edge so the load has logged it
	task automatic wait_lvl(input logic lvl);
		int n;
		n = 0;
		while (wave !== lvl && n < 1000) begin
			@(posedge clk_in);
			#1 n++;
		end
		if (n >= 1000) begin
			error_cnt++;
			complete_run();
		end
		@(posedge clk_in);
		#1;
	endtask : wait_lvl

	// Capture must land on a counter value seen around the edge
	task automatic cap_chk(input int ch, input logic lvl, input logic [2:0] a);
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] cv;
		reg_rd(TCP_A_CNT, b0);
		src_u.set_pin(ch, lvl);
		repeat (4) @(posedge clk_in);
		reg_rd(TCP_A_CNT, b1);
		reg_rd(a, cv);
		check({7'h00, (cv === b0) || (cv === b1)}, 8'h01);
	endtask : cap_chk

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		clk_in     = 1'b0;
		sys_rst_in = 1'b1;
		addr_in    = '0;
		wdata_in   = '0;
		wr_in      = 1'b0;
		rd_in      = 1'b0;
		mask_in    = 1'b1;
		halt_in    = 1'b0;
		error_cnt  = 0;
		cmp_count  = 0;
		repeat (3) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			rd_chk(3'(i), (i < 5) ? TCP_RST_REG : TCP_RST_CMP);
		end
		$display("test reset done");
		// Increments over a fixed 256-cycle window give the divide ratio
		for (int s = 0; s < 4; s++) begin
			reg_wr(TCP_A_CTRL2, 8'(s << TCP_B_CLK));
			repeat (300) @(posedge clk_in);
			reg_rd(TCP_A_CNT, c0);
			repeat (254) @(posedge clk_in);
			reg_rd(TCP_A_CNT, c1);
			check(8'(c1 - c0), 8'(256 >> (2 * s + 1)));
		end
		// An edge seen in halt waits and captures the count held at wake-up
		src_u.set_pin(1, 1'b1);
		@(posedge clk_in);
		halt_in <= 1'b1;
		reg_rd(TCP_A_CNT, c0);
		src_u.set_pin(1, 1'b0);
		repeat (200) @(posedge clk_in);
		rd_chk(TCP_A_CNT, c0);
		rd_chk(TCP_A_STAT, 8'h00);
		@(posedge clk_in);
		halt_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		rd_chk(TCP_A_STAT, 8'h80);
		rd_chk(TCP_A_CAP1, c0);
		$display("test counter done");
		// Channel one rising edge, request held back by the mask
		reg_wr(TCP_A_CTRL1, 8'h82);
		cap_chk(1, 1'b1, TCP_A_CAP1);
		rd_chk(TCP_A_STAT, 8'h80);
		check({7'h00, irq_out}, 8'h00);
		@(posedge clk_in);
		mask_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		#1 check({7'h00, irq_out}, 8'h01);
		// The status read above armed the clear; a capture register write ends it
		rd_chk(TCP_A_STAT, 8'h80);
		reg_wr(TCP_A_CAP1, 8'h5a);
		rd_chk(TCP_A_STAT, 8'h00);
		reg_rd(TCP_A_CAP1, c0);
		reg_wr(TCP_A_CAP1, ~c0);
		rd_chk(TCP_A_CAP1, c0);
		check({7'h00, irq_out}, 8'h00);
		src_u.set_pin(1, 1'b0);
		rd_chk(TCP_A_STAT, 8'h00);
		repeat (300) @(posedge clk_in);
		cap_chk(1, 1'b1, TCP_A_CAP1);
		reg_rd(TCP_A_CAP1, c1);
		check({7'h00, c1 !== c0}, 8'h01);
		rd_chk(TCP_A_STAT, 8'h80);
		reg_rd(TCP_A_CAP1, rv);
		$display("test channel one done");
		// Channel two on falling edge only
		src_u.set_pin(2, 1'b1);
		rd_chk(TCP_A_STAT, 8'h00);
		cap_chk(2, 1'b0, TCP_A_CAP2);
		rd_chk(TCP_A_STAT, 8'h40);
		reg_rd(TCP_A_CAP2, rv);
		// Single shot set: channel one deaf, channel two still live
		reg_wr(TCP_A_CTRL2, 8'h4e);
		src_u.set_pin(1, 1'b0);
		src_u.set_pin(1, 1'b1);
		rd_chk(TCP_A_STAT, 8'h00);
		cap_chk(2, 1'b1, TCP_A_CAP2);
		rd_chk(TCP_A_STAT, 8'h40);
		reg_rd(TCP_A_CAP2, rv);
		$display("test channel two done");
		// PWM at divide by two, single shot also set
		reg_wr(TCP_A_CMP1, 8'h02);
		reg_wr(TCP_A_CMP2, 8'h05);
		reg_wr(TCP_A_CTRL2, 8'hc0);
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		check(period_len[7:0], 8'h0c);
		h0 = high_len[7:0];
		reg_wr(TCP_A_CMP2, 8'h09);
		reg_wr(TCP_A_CMP1, 8'h04);
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		check(period_len[7:0], 8'h0c);
		wait_lvl(1'b0);
		check(high_len[7:0], 8'(h0 + 8'h04));
		wait_lvl(1'b1);
		check(period_len[7:0], 8'h14);
		reg_rd(TCP_A_STAT, rv);
		check({7'h00, rv[TCP_B_FLAG1]}, 8'h01);
		$display("test pwm done");
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
